// ---- hw/rafl_pkg.sv ----
package rafl_pkg;

  // ==========================================
  // widths
  localparam int unsigned RAFL_VW    = 16;
  localparam int unsigned RAFL_AW    = 8;
  localparam int unsigned RAFL_NFLAG = 11;

  // ==========================================
  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_SHTHR_A = 8'h04;
  localparam logic [7:0] OFF_SHTHR_B = 8'h08;
  localparam logic [7:0] OFF_RSTHR_A = 8'h0c;
  localparam logic [7:0] OFF_RSTHR_B = 8'h10;
  localparam logic [7:0] OFF_SHDLY_A = 8'h14;
  localparam logic [7:0] OFF_SHDLY_B = 8'h18;
  localparam logic [7:0] OFF_RSDLY_A = 8'h1c;
  localparam logic [7:0] OFF_RSDLY_B = 8'h20;
  localparam logic [7:0] OFF_UVTHR   = 8'h24;
  localparam logic [7:0] OFF_OVTHR   = 8'h28;
  localparam logic [7:0] OFF_CTTHR_A = 8'h2c;
  localparam logic [7:0] OFF_CTTHR_B = 8'h30;
  localparam logic [7:0] OFF_CNT_A   = 8'h34;
  localparam logic [7:0] OFF_CNT_B   = 8'h38;
  localparam logic [7:0] OFF_FLAGS   = 8'h3c;
  localparam logic [7:0] OFF_SEAL    = 8'h40;

  // ==========================================
  // control fields
  localparam int unsigned CTRL_DELTA  = 0;
  localparam int unsigned CTRL_TGTRST = 8;
  localparam int unsigned CTRL_CLR_A  = 9;
  localparam int unsigned CTRL_CLR_B  = 10;

  // ==========================================
  // flag positions
  localparam int unsigned FLG_SHED_A = 0;
  localparam int unsigned FLG_SHED_B = 1;
  localparam int unsigned FLG_REST_A = 2;
  localparam int unsigned FLG_REST_B = 3;
  localparam int unsigned FLG_OVF_A  = 4;
  localparam int unsigned FLG_OVF_B  = 5;
  localparam int unsigned FLG_UV     = 6;
  localparam int unsigned FLG_OV     = 7;
  localparam int unsigned FLG_RDIS   = 8;
  localparam int unsigned FLG_CNT_A  = 9;
  localparam int unsigned FLG_CNT_B  = 10;
  localparam logic [10:0] SEAL_MASK  = 11'h6ff;

  // ==========================================
  // reset values
  localparam logic [15:0] RST_LOW  = 16'h0000;
  localparam logic [15:0] RST_HIGH = 16'hffff;

  // ==========================================
  // bus responses, tag switch positions
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    POS_ON  = 2'h0,
    POS_OFF = 2'h1,
    POS_TAG = 2'h2
  } rafl_tag_pos_t;

endpackage

// ---- hw/rafl_freq_if.sv ----
`timescale 1ns/100ps
// ==========================================
// settings in, flags out, per frequency module
interface rafl_freq_if
#(
  parameter int unsigned VW = rafl_pkg::RAFL_VW
);
  logic          tick;
  logic [VW-1:0] freq;
  logic [VW-1:0] shed_thr;
  logic [VW-1:0] rest_thr;
  logic [VW-1:0] shed_dly;
  logic [VW-1:0] rest_dly;
  logic          shed;
  logic          restore;
  logic          overfreq;

  modport elem (
    input  tick, freq, shed_thr, rest_thr, shed_dly, rest_dly,
    output shed, restore, overfreq
  );
  modport ctrl (
    output tick, freq, shed_thr, rest_thr, shed_dly, rest_dly,
    input  shed, restore, overfreq
  );
endinterface

// ---- hw/rafl_freq_elem.sv ----
`timescale 1ns/100ps
module rafl_freq_elem
#(
  parameter int unsigned VW = rafl_pkg::RAFL_VW
)
(
  input wire logic  i_clock,
  input wire logic  i_rst,
  rafl_freq_if.elem fi
);
  import rafl_pkg::*;

  // ==========================================
  // delay timers, counted in evaluation ticks
  logic [VW-1:0] shed_cnt_q;
  logic [VW-1:0] rest_cnt_q;
  logic [VW-1:0] over_cnt_q;
  logic          shed_q;
  logic          rest_q;
  logic          over_q;
  logic          armed_q;
  wire           below_w;
  wire           met_w;
  wire           above_w;

  // saturating timer; restarts when the condition drops
  function automatic logic [VW-1:0] dly_step
  (
    input logic          cond,
    input logic          tick,
    input logic [VW-1:0] cnt,
    input logic [VW-1:0] dly
  );
    if (!cond)
      return '0;
    if (tick && cnt < dly)
      return VW'(cnt + 1'b1);
    return cnt;
  endfunction

  // frequency comparisons
  assign below_w = fi.freq < fi.shed_thr;
  assign met_w   = fi.freq >= fi.rest_thr;
  assign above_w = fi.freq > fi.rest_thr;

  // timers and flags
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      shed_cnt_q <= '0;
      rest_cnt_q <= '0;
      over_cnt_q <= '0;
      shed_q     <= 1'b0;
      rest_q     <= 1'b0;
      over_q     <= 1'b0;
      armed_q    <= 1'b0;
    end
    else
    begin
      shed_cnt_q <= dly_step(below_w, fi.tick, shed_cnt_q, fi.shed_dly);
      rest_cnt_q <= dly_step(met_w & armed_q, fi.tick, rest_cnt_q, fi.rest_dly);
      over_cnt_q <= dly_step(above_w, fi.tick, over_cnt_q, fi.rest_dly);
      shed_q     <= below_w && shed_cnt_q >= fi.shed_dly;
      rest_q     <= armed_q && met_w && rest_cnt_q >= fi.rest_dly;
      over_q     <= above_w && over_cnt_q >= fi.rest_dly;
      // arm only by a shed; shed wins over disarm
      armed_q    <= shed_q | (armed_q & ~(rest_q & ~met_w));
    end
  end

  assign fi.shed     = shed_q;
  assign fi.restore  = rest_q;
  assign fi.overfreq = over_q;

  // ==========================================
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_shed_low_freq: assert property (
    $rose(shed_q) |-> $past(below_w) && $past(shed_cnt_q >= fi.shed_dly))
    else $error("shed flag without low frequency and delay");
  a_shed_drops: assert property (
    !below_w |=> !shed_q)
    else $error("shed flag held after frequency recovered");
  a_restore_timed: assert property (
    $rose(rest_q) |-> $past(met_w) && $past(rest_cnt_q >= fi.rest_dly))
    else $error("restore flag without threshold and delay");
  a_restore_after_shed: assert property (
    $rose(rest_q) |-> $past(armed_q))
    else $error("restore flag without earlier shed");
  a_over_exceeds: assert property (
    $rose(over_q) |-> $past(above_w) && $past(over_cnt_q >= fi.rest_dly))
    else $error("overfrequency flag without cause");
  c_shed_then_restore: cover property (
    shed_q ##[1:1000] rest_q);
endmodule

// ---- hw/rafl_top.sv ----
`timescale 1ns/100ps
// ==========================================
module rafl_top
#(
  parameter int unsigned VAL_W = rafl_pkg::RAFL_VW
)
(
  input  wire logic                  i_clock,
  input  wire logic                  i_rst,
  input  wire logic                  i_tick,
  input  wire logic [VAL_W-1:0]      i_freq,
  input  wire logic [2:0][VAL_W-1:0] i_volt_phase,
  input  wire logic [2:0][VAL_W-1:0] i_volt_pair,
  input  wire logic                  i_recloser_block_input,
  input  wire logic                  i_lockout,
  input  wire logic [1:0]            i_hot_line_tag_function,
  input  wire logic                  i_reclose_op,
  input  wire logic                  i_target_reset,
  input  wire logic [7:0]            i_s_axi_awaddr,
  input  wire logic                  i_s_axi_awvalid,
  output logic                       o_s_axi_awready,
  input  wire logic [31:0]           i_s_axi_wdata,
  input  wire logic [3:0]            i_s_axi_wstrb,
  input  wire logic                  i_s_axi_wvalid,
  output logic                       o_s_axi_wready,
  output logic [1:0]                 o_s_axi_bresp,
  output logic                       o_s_axi_bvalid,
  input  wire logic                  i_s_axi_bready,
  input  wire logic [7:0]            i_s_axi_araddr,
  input  wire logic                  i_s_axi_arvalid,
  output logic                       o_s_axi_arready,
  output logic [31:0]                o_s_axi_rdata,
  output logic [1:0]                 o_s_axi_rresp,
  output logic                       o_s_axi_rvalid,
  input  wire logic                  i_s_axi_rready,
  output logic [10:0]                o_flags,
  output logic [10:0]                o_seal
);
  import rafl_pkg::*;

  // ==========================================
  // settings and state
  logic [VAL_W-1:0] shthr_q [2];
  logic [VAL_W-1:0] rsthr_q [2];
  logic [VAL_W-1:0] shdly_q [2];
  logic [VAL_W-1:0] rsdly_q [2];
  logic [VAL_W-1:0] ctthr_q [2];
  logic [VAL_W-1:0] cnt_q   [2];
  logic [VAL_W-1:0] uvthr_q;
  logic [VAL_W-1:0] ovthr_q;
  logic             delta_q;
  logic [10:0]      flags_d;
  logic [10:0]      seal_d;

  // ==========================================
  // bus slave state
  logic        aw_full_q;
  logic        w_full_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  wire         wr_go_w;
  wire         wr_map_w;
  wire         rd_map_w;
  wire  [31:0] rd_word_w;
  wire         tgt_rst_w;
  wire  [1:0]  clr_w;

  // merge byte lanes into a 16-bit setting
  function automatic logic [VAL_W-1:0] merge
  (
    input logic [VAL_W-1:0] old,
    input logic [31:0]      data,
    input logic [3:0]       strb
  );
    logic [15:0] res;
    res = 16'(old);
    if (strb[0])
      res[7:0] = data[7:0];
    if (strb[1])
      res[15:8] = data[15:8];
    return VAL_W'(res);
  endfunction

  // register read mux; unmapped reads zero
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    unique case (a)
      OFF_CTRL:    return 32'(delta_q);
      OFF_SHTHR_A: return 32'(shthr_q[0]);
      OFF_SHTHR_B: return 32'(shthr_q[1]);
      OFF_RSTHR_A: return 32'(rsthr_q[0]);
      OFF_RSTHR_B: return 32'(rsthr_q[1]);
      OFF_SHDLY_A: return 32'(shdly_q[0]);
      OFF_SHDLY_B: return 32'(shdly_q[1]);
      OFF_RSDLY_A: return 32'(rsdly_q[0]);
      OFF_RSDLY_B: return 32'(rsdly_q[1]);
      OFF_UVTHR:   return 32'(uvthr_q);
      OFF_OVTHR:   return 32'(ovthr_q);
      OFF_CTTHR_A: return 32'(ctthr_q[0]);
      OFF_CTTHR_B: return 32'(ctthr_q[1]);
      OFF_CNT_A:   return 32'(cnt_q[0]);
      OFF_CNT_B:   return 32'(cnt_q[1]);
      OFF_FLAGS:   return 32'(o_flags);
      OFF_SEAL:    return 32'(o_seal);
      default:     return 32'h0000_0000;
    endcase
  endfunction

  // mapped offsets are word aligned and at most the seal word
  function automatic logic is_mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= OFF_SEAL;
  endfunction

  // write decode; a write lands once both halves are held
  assign wr_go_w   = aw_full_q && w_full_q && !o_s_axi_bvalid;
  assign wr_map_w  = is_mapped(awaddr_q);
  assign rd_map_w  = is_mapped(i_s_axi_araddr);
  assign rd_word_w = rd_mux(i_s_axi_araddr);
  // command bits act as one-cycle pulses, never stored
  assign tgt_rst_w = i_target_reset
                   || (wr_go_w && awaddr_q == OFF_CTRL
                       && wstrb_q[1] && wdata_q[CTRL_TGTRST]);
  assign clr_w[0]  = wr_go_w && awaddr_q == OFF_CTRL
                   && wstrb_q[1] && wdata_q[CTRL_CLR_A];
  assign clr_w[1]  = wr_go_w && awaddr_q == OFF_CTRL
                   && wstrb_q[1] && wdata_q[CTRL_CLR_B];

  // ==========================================
  // write channel; address and data taken in any order
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      aw_full_q       <= 1'b0;
      w_full_q        <= 1'b0;
      awaddr_q        <= 8'h00;
      wdata_q         <= 32'h0000_0000;
      wstrb_q         <= 4'h0;
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready  <= 1'b1;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      if (i_s_axi_awvalid && o_s_axi_awready)
      begin
        aw_full_q       <= 1'b1;
        awaddr_q        <= i_s_axi_awaddr;
        o_s_axi_awready <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready)
      begin
        w_full_q       <= 1'b1;
        wdata_q        <= i_s_axi_wdata;
        wstrb_q        <= i_s_axi_wstrb;
        o_s_axi_wready <= 1'b0;
      end
      if (wr_go_w)
      begin
        aw_full_q      <= 1'b0;
        w_full_q       <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= wr_map_w ? RESP_OKAY : RESP_SLVERR;
      end
      if (o_s_axi_bvalid && i_s_axi_bready)
      begin
        o_s_axi_bvalid  <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready  <= 1'b1;
      end
    end
  end

  // ==========================================
  // settings written by software; read-only words ignore writes
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      delta_q <= 1'b0;
      uvthr_q <= VAL_W'(RST_LOW);
      ovthr_q <= VAL_W'(RST_HIGH);
      for (int m = 0; m < 2; m++)
      begin
        shthr_q[m] <= VAL_W'(RST_LOW);
        rsthr_q[m] <= VAL_W'(RST_HIGH);
        shdly_q[m] <= VAL_W'(RST_LOW);
        rsdly_q[m] <= VAL_W'(RST_LOW);
        ctthr_q[m] <= VAL_W'(RST_HIGH);
      end
    end
    else if (wr_go_w)
    begin
      unique case (awaddr_q)
        OFF_CTRL:
          if (wstrb_q[0])
            delta_q <= wdata_q[CTRL_DELTA];
        OFF_SHTHR_A: shthr_q[0] <= merge(shthr_q[0], wdata_q, wstrb_q);
        OFF_SHTHR_B: shthr_q[1] <= merge(shthr_q[1], wdata_q, wstrb_q);
        OFF_RSTHR_A: rsthr_q[0] <= merge(rsthr_q[0], wdata_q, wstrb_q);
        OFF_RSTHR_B: rsthr_q[1] <= merge(rsthr_q[1], wdata_q, wstrb_q);
        OFF_SHDLY_A: shdly_q[0] <= merge(shdly_q[0], wdata_q, wstrb_q);
        OFF_SHDLY_B: shdly_q[1] <= merge(shdly_q[1], wdata_q, wstrb_q);
        OFF_RSDLY_A: rsdly_q[0] <= merge(rsdly_q[0], wdata_q, wstrb_q);
        OFF_RSDLY_B: rsdly_q[1] <= merge(rsdly_q[1], wdata_q, wstrb_q);
        OFF_UVTHR:   uvthr_q    <= merge(uvthr_q, wdata_q, wstrb_q);
        OFF_OVTHR:   ovthr_q    <= merge(ovthr_q, wdata_q, wstrb_q);
        OFF_CTTHR_A: ctthr_q[0] <= merge(ctthr_q[0], wdata_q, wstrb_q);
        OFF_CTTHR_B: ctthr_q[1] <= merge(ctthr_q[1], wdata_q, wstrb_q);
        default:     ;
      endcase
    end
  end

  // ==========================================
  // read channel; one cycle from address to data
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0000_0000;
      o_s_axi_rresp   <= RESP_OKAY;
    end
    else if (i_s_axi_arvalid && o_s_axi_arready)
    begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b1;
      o_s_axi_rdata   <= rd_word_w;
      o_s_axi_rresp   <= rd_map_w ? RESP_OKAY : RESP_SLVERR;
    end
    else if (o_s_axi_rvalid && i_s_axi_rready)
    begin
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_arready <= 1'b1;
    end
  end

  // ==========================================
  // two frequency modules
  logic [1:0] shed_w;
  logic [1:0] rest_w;
  logic [1:0] ovf_w;
  for (genvar g = 0; g < 2; g++)
  begin : g_mod
    rafl_freq_if #(.VW(VAL_W)) fif ();
    assign fif.tick     = i_tick;
    assign fif.freq     = i_freq;
    assign fif.shed_thr = shthr_q[g];
    assign fif.rest_thr = rsthr_q[g];
    assign fif.shed_dly = shdly_q[g];
    assign fif.rest_dly = rsdly_q[g];
    assign shed_w[g]    = fif.shed;
    assign rest_w[g]    = fif.restore;
    assign ovf_w[g]     = fif.overfreq;
    rafl_freq_elem #(.VW(VAL_W)) u_elem
    (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .fi      (fif.elem)
    );
  end

  // ==========================================
  // voltage, recloser and counter conditions
  wire [2:0][VAL_W-1:0] volt_w = delta_q ? i_volt_pair : i_volt_phase;
  wire uv_w = volt_w[0] < uvthr_q || volt_w[1] < uvthr_q
           || volt_w[2] < uvthr_q;
  wire ov_w = volt_w[0] > ovthr_q || volt_w[1] > ovthr_q
           || volt_w[2] > ovthr_q;
  wire tag_w = i_hot_line_tag_function == POS_OFF
            || i_hot_line_tag_function == POS_TAG;
  wire rdis_w = i_recloser_block_input || i_lockout || tag_w;

  // flag assembly; these are flags only, routing to trip or
  // close is left to the feedback logic outside
  always_comb
  begin
    flags_d[FLG_SHED_A] = shed_w[0];
    flags_d[FLG_SHED_B] = shed_w[1];
    flags_d[FLG_REST_A] = rest_w[0];
    flags_d[FLG_REST_B] = rest_w[1];
    flags_d[FLG_OVF_A]  = ovf_w[0];
    flags_d[FLG_OVF_B]  = ovf_w[1];
    flags_d[FLG_UV]     = uv_w;
    flags_d[FLG_OV]     = ov_w;
    flags_d[FLG_RDIS]   = rdis_w;
    flags_d[FLG_CNT_A]  = cnt_q[0] > ctthr_q[0];
    flags_d[FLG_CNT_B]  = cnt_q[1] > ctthr_q[1];
    // companions, set wins over target reset
    seal_d = (tgt_rst_w ? 11'h000 : o_seal) | (flags_d & SEAL_MASK);
  end

  // flags, seal-ins and recloser operation counters
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_flags <= 11'h000;
      o_seal  <= 11'h000;
      cnt_q[0] <= VAL_W'(RST_LOW);
      cnt_q[1] <= VAL_W'(RST_LOW);
    end
    else
    begin
      o_flags <= flags_d;
      o_seal  <= seal_d;
      for (int c = 0; c < 2; c++)
      begin
        if (clr_w[c])
          cnt_q[c] <= VAL_W'(i_reclose_op);
        else if (i_reclose_op && cnt_q[c] != '1)
          cnt_q[c] <= VAL_W'(cnt_q[c] + 1'b1);
      end
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_uv_any_phase: assert property (
    ##1 o_flags[FLG_UV] == $past(uv_w))
    else $error("undervoltage flag does not follow voltages");
  a_ov_any_phase: assert property (
    ##1 o_flags[FLG_OV] == $past(ov_w))
    else $error("overvoltage flag does not follow voltages");
  a_rdis_sources: assert property (
    (i_recloser_block_input || i_lockout) |=> o_flags[FLG_RDIS])
    else $error("recloser disabled flag missing");
  a_rdis_tag: assert property (
    tag_w |=> o_flags[FLG_RDIS])
    else $error("recloser disabled flag missing for tag");
  a_cnt_alarm: assert property (
    ##1 o_flags[FLG_CNT_A] == $past(cnt_q[0] > ctthr_q[0]))
    else $error("counter alarm does not follow count");
  a_cnt_clear_indep: assert property (
    clr_w[0] && !clr_w[1] && !i_reclose_op
    |=> cnt_q[0] == '0 && $stable(cnt_q[1]))
    else $error("counter clear not independent");
  a_seal_covers_base: assert property (
    ((o_flags & SEAL_MASK) & ~o_seal) == 11'h000)
    else $error("seal-in missing for active flag");
  a_seal_holds: assert property (
    !tgt_rst_w |=> (o_seal & $past(o_seal)) == $past(o_seal))
    else $error("seal-in dropped without target reset");
  a_bvalid_holds: assert property (
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
    else $error("write response dropped before taken");
  c_shed_a: cover property ($rose(o_flags[FLG_SHED_A]));
  c_rest_b: cover property ($rose(o_flags[FLG_REST_B]));
  c_cnt_b: cover property ($rose(o_flags[FLG_CNT_B]));
  c_write: cover property (o_s_axi_bvalid && i_s_axi_bready);
endmodule

// ---- verif/rafl_front_end.sv ----
`timescale 1ns/100ps
// ==========================================
// measurement front end: evaluation tick every TP clocks
module rafl_front_end
#(
  parameter int unsigned TP = 4
)
(
  input  wire logic i_clock,
  input  wire logic i_rst,
  output logic      o_tick
);
  logic [7:0] cnt_q;

  // one-cycle tick; held off in reset so delays start clean
  always_ff @(posedge i_clock)
  begin
    if (i_rst || cnt_q == 8'(TP - 1)) cnt_q <= 8'h00;
    else cnt_q <= cnt_q + 8'h01;
    o_tick <= !i_rst && cnt_q == 8'(TP - 1);
  end
endmodule

// ---- verif/rafl_tb_top.sv ----
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module rafl_tb_top;
  import rafl_pkg::*;
  typedef struct packed {
    logic             dl;
    logic [2:0][15:0] ph;
    logic [2:0][15:0] pr;
    logic [1:0]       uo;
  } rafl_vrow_t;
  // ==========================================
  // stimulus and observed signals
  logic             i_clock = 1'b0;
  logic             rst     = 1'b1;
  logic             tick;
  logic [15:0]      freq    = 16'h173e;
  logic [2:0][15:0] vph     = {3{16'h0096}};
  logic [2:0][15:0] vpr     = {3{16'h0096}};
  logic             blk     = 1'b0;
  logic             lock    = 1'b0;
  logic [1:0]       tagp    = 2'h0;
  logic             rop     = 1'b0;
  logic             trst    = 1'b0;
  logic [7:0]       awaddr  = 8'h00;
  logic             awvalid = 1'b0;
  logic [31:0]      wdata   = 32'h0000_0000;
  logic [3:0]       wstrb   = 4'hf;
  logic             wvalid  = 1'b0;
  logic             bready  = 1'b1; // responses always accepted
  logic [7:0]       araddr  = 8'h00;
  logic             arvalid = 1'b0;
  logic             rready  = 1'b1;
  logic             awready, wready, bvalid, arready, rvalid;
  logic [1:0]       bresp, rresp;
  logic [31:0]      rdata;
  logic [10:0]      flags, seal;
  int               errors  = 0;
  int               checked = 0;
  // settings: uv, ov, shed/restore per module, count thresholds
  logic [7:0]  cfg_a [10] = '{OFF_UVTHR, OFF_OVTHR, OFF_SHTHR_A, OFF_SHTHR_B, OFF_SHDLY_A,
                              OFF_RSTHR_A, OFF_RSDLY_A, OFF_RSTHR_B, OFF_CTTHR_A, OFF_CTTHR_B};
  logic [15:0] cfg_d [10] = '{16'h0064, 16'h00c8, 16'h170c, 16'h1600, 16'h0003,
                              16'h1766, 16'h0002, 16'h1766, 16'h0002, 16'h0003};
  // voltage rows; last row sits on both thresholds, which must not alarm
  rafl_vrow_t  vrows [6] = '{
    '{1'b0, {3{16'h0096}}, {3{16'h0032}}, 2'h0},
    '{1'b0, {16'h0096, 16'h0063, 16'h0096}, {3{16'h0096}}, 2'h2},
    '{1'b0, {16'h0096, 16'h0096, 16'h00c9}, {3{16'h0096}}, 2'h1},
    '{1'b1, {3{16'h0032}}, {16'h0063, 16'h0096, 16'h0096}, 2'h2},
    '{1'b1, {3{16'h0096}}, {16'h0096, 16'h00c9, 16'h0096}, 2'h1},
    '{1'b0, {16'h0064, 16'h00c8, 16'h0096}, {3{16'h0096}}, 2'h0}};

  always #2 i_clock = ~i_clock;

  rafl_front_end u_rafl_front_end (.i_clock(i_clock), .i_rst(rst), .o_tick(tick));

  rafl_top u_rafl_top (
    .i_clock(i_clock), .i_rst(rst), .i_tick(tick), .i_freq(freq),
    .i_volt_phase(vph), .i_volt_pair(vpr), .i_recloser_block_input(blk),
    .i_lockout(lock), .i_hot_line_tag_function(tagp), .i_reclose_op(rop),
    .i_target_reset(trst), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .o_flags(flags), .o_seal(seal));

  task automatic print_verdict;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // bus write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do
    begin
      @(posedge i_clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end
    while (!bvalid && n < 40);
    if (n >= 40) begin errors++; print_verdict(); end
    `CHK(bresp, er)
  endtask

  // bus read with data and response compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge i_clock);
      if (arready) arvalid <= 1'b0;
      n++;
    end
    while (!rvalid && n < 40);
    if (n >= 40) begin errors++; print_verdict(); end
    `CHK(rdata, ed)
    `CHK(rresp, er)
  endtask

  task automatic pulse_op;
    rop <= 1'b1;
    @(posedge i_clock);
    rop <= 1'b0;
    @(posedge i_clock);
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    step(2);
    rst <= 1'b0;
    `CHK(flags, 11'h000)
    rdc(OFF_SHTHR_A, 32'h0000_0000, RESP_OKAY);
    rdc(OFF_OVTHR, 32'h0000_ffff, RESP_OKAY);
    foreach (cfg_a[k]) wr(cfg_a[k], cfg_d[k], RESP_OKAY);
    step(20);
    `CHK(flags[5:0], 6'h00)
    freq <= 16'h1770;
    step(20);
    `CHK(flags[5:0], 6'h30)
    freq <= 16'h16a8;
    step(5);
    `CHK(flags[FLG_SHED_A], 1'b0)
    step(20);
    `CHK(flags[5:0], 6'h01)
    freq <= 16'h1770;
    step(20);
    `CHK(flags[5:0], 6'h34)
    `CHK(seal[5:0], 6'h35)
    foreach (vrows[k])
    begin
      wr(OFF_CTRL, {15'h0000, vrows[k].dl}, RESP_OKAY);
      vph <= vrows[k].ph;
      vpr <= vrows[k].pr;
      step(3);
      `CHK({flags[FLG_UV], flags[FLG_OV]}, vrows[k].uo)
    end
    `CHK(seal[7:6], 2'h3)
    trst <= 1'b1;
    step(1);
    trst <= 1'b0;
    step(3);
    `CHK(seal, 11'h034)
    for (int k = 0; k < 16; k++)
    begin
      {blk, lock, tagp} <= 4'(k);
      step(3);
      `CHK(flags[FLG_RDIS], blk | lock | tagp == POS_OFF | tagp == POS_TAG)
      `CHK(seal[FLG_RDIS], 1'b0)
    end
    // release recloser inputs so the later reset starts quiet
    {blk, lock, tagp} <= 4'h0;
    // deep dip sheds both modules, module b with no delay
    freq <= 16'h1500;
    step(25);
    `CHK(flags[5:0], 6'h03)
    // recovery restores both, each only after its own shed
    freq <= 16'h1770;
    step(20);
    `CHK(flags[5:0], 6'h3c)
    repeat (3) pulse_op();
    step(2);
    `CHK(flags[10:9], 2'h1)
    rdc(OFF_CNT_A, 32'h0000_0003, RESP_OKAY);
    wr(OFF_CTRL, 16'h0200, RESP_OKAY);
    step(2);
    rdc(OFF_CNT_A, 32'h0000_0000, RESP_OKAY);
    rdc(OFF_CNT_B, 32'h0000_0003, RESP_OKAY);
    `CHK({seal[FLG_CNT_A], flags[FLG_CNT_A]}, 2'h2)
    pulse_op();
    step(2);
    `CHK(flags[10:9], 2'h2)
    wr(OFF_CTRL, 16'h0100, RESP_OKAY);
    step(2);
    `CHK(seal[10:9], 2'h2)
    // refusals: unmapped, unaligned; read-only write answered OKAY and ignored
    wr(8'h44, 16'h1234, RESP_SLVERR);
    wr(8'h05, 16'h1234, RESP_SLVERR);
    wr(OFF_CNT_B, 16'h0000, RESP_OKAY);
    rdc(OFF_CNT_B, 32'h0000_0004, RESP_OKAY);
    rdc(8'h44, 32'h0000_0000, RESP_SLVERR);
    rst <= 1'b1;
    step(2);
    rst <= 1'b0;
    step(1);
    `CHK({flags, seal}, 22'h00_0000)
    `CHK({awready, wready, arready, bvalid, rvalid}, 5'h1c)
    print_verdict();
  end
endmodule
